// ==== trainer_cfg.svh ====
// offsets, field positions, reset values and timing of the trainer port block
`ifndef TRAINER_CFG_SVH
`define TRAINER_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_FIRST_PORT 4'h4
`define REG_SECOND_PORT 4'h8
`define REG_STATUS 4'hc

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_P1_SEL_LSB 0
`define CTRL_X_SEL_LSB 2
`define CTRL_Y_SEL_LSB 4
`define CTRL_SPLIT_BIT 6
`define CTRL_ROW2_MON_BIT 7
`define CTRL_CYCLE_BIT 8
`define CTRL_WAIT_LINK_BIT 9
`define CTRL_RESET 10'h027

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define STAT_BUS_LSB 0
`define STAT_MON_LSB 8
`define STAT_RUN_BIT 16
`define STAT_BUTTON_BIT 17

// ----------------------------------------------------------------
// i/o port numbers
// ----------------------------------------------------------------
`define PORT_ADDR_FD 8'hfd
`define PORT_ADDR_FE 8'hfe
`define PORT_ADDR_FF 8'hff

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLOCK_HZ 10000000
`define DEBOUNCE_TIME_US 10000
`define DEBOUNCE_CYCLES ((`DEBOUNCE_TIME_US * (`CLOCK_HZ / 1000000)))

`endif

// ==== trainer_pkg.sv ====
// types shared by the trainer port block
package trainer_pkg;

   typedef enum logic [1:0]
   {
      sel_none = 2'b00,
      sel_fd = 2'b01,
      sel_fe = 2'b10,
      sel_ff = 2'b11
   } port_sel_t;

   typedef enum logic
   {
      step_hold = 1'b0,
      step_run = 1'b1
   } step_state_t;

endpackage : trainer_pkg

// ==== io_strobe_decoder.sv ====
// i/o write strobe decoder for port numbers fd, fe and ff
`include "trainer_cfg.svh"

module io_strobe_decoder
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // processor bus
   input wire logic [7:0] port_addr,
   input wire logic [7:0] bus_data,
   input wire logic io_request_n,
   input wire logic write_n,
   // strobes and captured byte
   output logic write_strobe_addr_fd,
   output logic write_strobe_addr_fe,
   output logic write_strobe_addr_ff,
   output logic [7:0] strobe_data
);
   import trainer_pkg::*;

   logic io_write;
   logic io_write_prev;
   logic write_start;
   logic hit_fd;
   logic hit_fe;
   logic hit_ff;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   assign io_write = !io_request_n && !write_n;
   assign write_start = io_write && !io_write_prev;
   assign hit_fd = write_start && (port_addr == `PORT_ADDR_FD);
   assign hit_fe = write_start && (port_addr == `PORT_ADDR_FE);
   assign hit_ff = write_start && (port_addr == `PORT_ADDR_FF);

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         io_write_prev <= 1'b0;
         write_strobe_addr_fd <= 1'b0;
         write_strobe_addr_fe <= 1'b0;
         write_strobe_addr_ff <= 1'b0;
         strobe_data <= 8'h00;
      end
      else
      begin
         io_write_prev <= io_write;
         write_strobe_addr_fd <= hit_fd;
         write_strobe_addr_fe <= hit_fe;
         write_strobe_addr_ff <= hit_ff;
         if (write_start)
            strobe_data <= bus_data;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_fd_strobe;
      @(posedge clock) disable iff (!resetn)
      (!io_request_n && !write_n && port_addr == `PORT_ADDR_FD && !$past(io_write))
      |=> write_strobe_addr_fd && strobe_data == $past(bus_data) ##1 !write_strobe_addr_fd;
   endproperty
   a_fd_strobe: assert property (p_fd_strobe) else $error("fd strobe missing");

endmodule : io_strobe_decoder

// ==== push_button_filter.sv ====
// push-button synchroniser and debouncer with press pulse
module push_button_filter
#(
   parameter int unsigned SETTLE_CYCLES = 100000
)
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // raw button, active high when pressed
   input wire logic button_raw,
   // filtered level and press pulse
   output logic button_level,
   output logic button_press
);
   logic sync_a;
   logic sync_b;
   logic [16:0] settle_count;
   logic settled;

   // ----------------------------------------------------------------
   // sync and settle
   // ----------------------------------------------------------------
   assign settled = (settle_count == 17'(SETTLE_CYCLES - 1));

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         settle_count <= 17'h00000;
         button_level <= 1'b0;
         button_press <= 1'b0;
      end
      else
      begin
         sync_a <= button_raw;
         sync_b <= sync_a;
         button_press <= 1'b0;
         if (sync_b == button_level)
            settle_count <= 17'h00000;
         else if (settled)
         begin
            settle_count <= 17'h00000;
            button_level <= sync_b;
            button_press <= sync_b;
         end
         else
            settle_count <= settle_count + 17'h00001;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_press_edge;
      @(posedge clock) disable iff (!resetn)
      button_press |-> button_level && !$past(button_level) ##1 !button_press;
   endproperty
   a_press_edge: assert property (p_press_edge) else $error("press not a single edge");

endmodule : push_button_filter

// ==== trainer_ports.sv ====
// trainer output ports, bus monitor and single machine cycle stepper
//
// Notes on behaviour
// - each port latches the written byte at its jumpered port number fd, fe or ff.
// - second port may split into two nibble latches with own port numbers.
// - first indicator row shows the data bus every cycle, either direction.
// - in cycle mode each button press lets exactly one machine cycle run.
// - stepping acts only when the hold output is linked to wait.
// - decoder makes one i/o write strobe per port number from address and control.
// - in monitor mode second row bit n follows monitor input n.
// - each latch loads only on a pulse of its own chosen strobe.
`include "trainer_cfg.svh"

module trainer_ports
   import trainer_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
)
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // avalon-mm slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // processor bus
   input wire logic [15:0] cpu_address,
   input wire logic [7:0] cpu_data,
   input wire logic io_request_n,
   input wire logic write_n,
   input wire logic machine_cycle_sync,
   input wire logic external_wait_n,
   output logic wait_n,
   // decoder strobes
   output logic write_strobe_addr_fd,
   output logic write_strobe_addr_fe,
   output logic write_strobe_addr_ff,
   // panel
   input wire logic step_pushbutton,
   input wire logic [7:0] monitor_inputs,
   output logic [7:0] bus_monitor_leds,
   output logic [7:0] first_port_leds,
   output logic [7:0] second_port_leds
);
   import trainer_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   port_sel_t first_sel;
   port_sel_t half_x_sel;
   port_sel_t half_y_sel;
   logic split_mode;
   logic row2_monitor;
   logic cycle_mode;
   logic wait_linked;
   logic [7:0] strobe_data;
   logic [7:0] second_port_latch;
   logic first_port_latch_strobe;
   logic half_x_latch_strobe;
   logic half_y_latch_strobe;
   logic button_level;
   logic button_press;
   step_state_t step_state;
   step_state_t next_step_state;
   logic stepping;
   logic bus_access;
   logic taken;
   logic ctrl_write;
   logic [7:0] next_second_port;
   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic [31:0] next_readdata;

   // ----------------------------------------------------------------
   // strobe choice
   // ----------------------------------------------------------------
   function automatic logic pick_strobe(input port_sel_t sel, input logic fd,
                                        input logic fe, input logic ff);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         sel_none: hit = 1'b0;
         sel_fd: hit = fd;
         sel_fe: hit = fe;
         sel_ff: hit = ff;
      endcase
      return hit;
   endfunction : pick_strobe

   io_strobe_decoder decoder
   (
      .clock(clock),
      .resetn(resetn),
      .port_addr(cpu_address[7:0]),
      .bus_data(cpu_data),
      .io_request_n(io_request_n),
      .write_n(write_n),
      .write_strobe_addr_fd(write_strobe_addr_fd),
      .write_strobe_addr_fe(write_strobe_addr_fe),
      .write_strobe_addr_ff(write_strobe_addr_ff),
      .strobe_data(strobe_data)
   );

   assign first_port_latch_strobe = pick_strobe(first_sel, write_strobe_addr_fd,
      write_strobe_addr_fe, write_strobe_addr_ff);
   assign half_x_latch_strobe = pick_strobe(half_x_sel, write_strobe_addr_fd,
      write_strobe_addr_fe, write_strobe_addr_ff);
   assign half_y_latch_strobe = split_mode && pick_strobe(half_y_sel, write_strobe_addr_fd,
      write_strobe_addr_fe, write_strobe_addr_ff);

   // ----------------------------------------------------------------
   // output latches
   // ----------------------------------------------------------------
   always_comb
   begin
      next_second_port = second_port_latch;
      if (split_mode)
      begin
         if (half_x_latch_strobe)
            next_second_port[3:0] = strobe_data[3:0];
         if (half_y_latch_strobe)
            next_second_port[7:4] = strobe_data[7:4];
      end
      else if (half_x_latch_strobe)
         next_second_port = strobe_data;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         first_port_leds <= 8'h00;
         second_port_latch <= 8'h00;
         second_port_leds <= 8'h00;
         bus_monitor_leds <= 8'h00;
      end
      else
      begin
         if (first_port_latch_strobe)
            first_port_leds <= strobe_data;
         second_port_latch <= next_second_port;
         second_port_leds <= row2_monitor ? monitor_inputs : next_second_port;
         bus_monitor_leds <= cpu_data;
      end
   end

   // ----------------------------------------------------------------
   // single cycle stepper
   // ----------------------------------------------------------------
   push_button_filter #(.SETTLE_CYCLES(DEBOUNCE_CYCLES)) button
   (
      .clock(clock),
      .resetn(resetn),
      .button_raw(step_pushbutton),
      .button_level(button_level),
      .button_press(button_press)
   );

   assign stepping = cycle_mode && wait_linked;

   always_comb
   begin
      next_step_state = step_state;
      unique case (step_state)
         step_hold:
            if (button_press)
               next_step_state = step_run;
         step_run:
            if (machine_cycle_sync)
               next_step_state = step_hold;
      endcase
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         step_state <= step_hold;
         wait_n <= 1'b1;
      end
      else
      begin
         step_state <= next_step_state;
         wait_n <= stepping ? (next_step_state == step_run) : external_wait_n;
      end
   end

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   assign bus_access = read || write;
   assign taken = bus_access && !waitrequest;
   assign ctrl_write = taken && write && (address == `REG_CTRL);
   assign ctrl_word = {22'h000000, wait_linked, cycle_mode, row2_monitor, split_mode,
      half_y_sel, half_x_sel, first_sel};
   assign status_word = {14'h0000, button_level, (step_state == step_run),
      monitor_inputs, bus_monitor_leds};

   always_comb
   begin
      next_readdata = 32'h00000000;
      unique case (address)
         `REG_CTRL: next_readdata = ctrl_word;
         `REG_FIRST_PORT: next_readdata = {24'h000000, first_port_leds};
         `REG_SECOND_PORT: next_readdata = {24'h000000, second_port_latch};
         `REG_STATUS: next_readdata = status_word;
         default: next_readdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end
      else
      begin
         waitrequest <= !(bus_access && waitrequest);
         if (read && waitrequest)
            readdata <= next_readdata;
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         first_sel <= port_sel_t'(2'(`CTRL_RESET >> `CTRL_P1_SEL_LSB));
         half_x_sel <= port_sel_t'(2'(`CTRL_RESET >> `CTRL_X_SEL_LSB));
         half_y_sel <= port_sel_t'(2'(`CTRL_RESET >> `CTRL_Y_SEL_LSB));
         split_mode <= 1'b0;
         row2_monitor <= 1'b0;
         cycle_mode <= 1'b0;
         wait_linked <= 1'b0;
      end
      else if (ctrl_write)
      begin
         if (byteenable[0])
         begin
            first_sel <= port_sel_t'(writedata[`CTRL_P1_SEL_LSB +: 2]);
            half_x_sel <= port_sel_t'(writedata[`CTRL_X_SEL_LSB +: 2]);
            half_y_sel <= port_sel_t'(writedata[`CTRL_Y_SEL_LSB +: 2]);
            split_mode <= writedata[`CTRL_SPLIT_BIT];
            row2_monitor <= writedata[`CTRL_ROW2_MON_BIT];
         end
         if (byteenable[1])
         begin
            cycle_mode <= writedata[`CTRL_CYCLE_BIT];
            wait_linked <= writedata[`CTRL_WAIT_LINK_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_first_load;
      @(posedge clock) disable iff (!resetn)
      first_port_latch_strobe |=> first_port_leds == $past(strobe_data);
   endproperty
   a_first_load: assert property (p_first_load) else $error("port one did not load");

   property p_first_hold;
      @(posedge clock) disable iff (!resetn)
      !first_port_latch_strobe |=> $stable(first_port_leds);
   endproperty
   a_first_hold: assert property (p_first_hold) else $error("port one changed unstrobed");

   property p_split_x;
      @(posedge clock) disable iff (!resetn)
      split_mode && half_x_latch_strobe && !half_y_latch_strobe
      |=> second_port_latch[3:0] == $past(strobe_data[3:0]) && $stable(second_port_latch[7:4]);
   endproperty
   a_split_x: assert property (p_split_x) else $error("split half x wrong");

   property p_bus_monitor;
      @(posedge clock) disable iff (!resetn)
      ##1 bus_monitor_leds == $past(cpu_data);
   endproperty
   a_bus_monitor: assert property (p_bus_monitor) else $error("bus monitor lags");

   property p_one_cycle;
      @(posedge clock) disable iff (!resetn)
      stepping && step_state == step_hold && button_press && $stable(stepping)
      |=> wait_n && step_state == step_run;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("press did not release");

   property p_rehold;
      @(posedge clock) disable iff (!resetn)
      stepping && step_state == step_run && machine_cycle_sync && $stable(stepping)
      |=> !wait_n && step_state == step_hold;
   endproperty
   a_rehold: assert property (p_rehold) else $error("wait not reasserted");

   property p_unlinked;
      @(posedge clock) disable iff (!resetn)
      !stepping |=> wait_n == $past(external_wait_n);
   endproperty
   a_unlinked: assert property (p_unlinked) else $error("outside wait not passed");

   property p_row2_monitor;
      @(posedge clock) disable iff (!resetn)
      row2_monitor |=> second_port_leds == $past(monitor_inputs);
   endproperty
   a_row2_monitor: assert property (p_row2_monitor) else $error("row two not following");

endmodule : trainer_ports

// ==== cpu_bus_model.sv ====
// processor-side bus model that drives the trainer port block
module cpu_bus_model
(
   // clock
   input wire logic clock,
   // hold from the block
   input wire logic wait_n,
   // processor bus
   output logic [15:0] cpu_address,
   output logic [7:0] cpu_data,
   output logic io_request_n,
   output logic write_n,
   output logic machine_cycle_sync,
   output logic external_wait_n
);
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------
   // bus cycles
   // ----------------------------------------------------------------
   initial
   begin
      cpu_address = 16'h0000;
      cpu_data = 8'h00;
      io_request_n = 1'b1;
      write_n = 1'b1;
      machine_cycle_sync = 1'b0;
      external_wait_n = 1'b1;
   end

   // i/o write, bus turned round after the cycle
   task io_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      cpu_address <= a;
      cpu_data <= d;
      io_request_n <= 1'b0;
      write_n <= 1'b0;
      repeat (3) @(posedge clock);
      io_request_n <= 1'b1;
      write_n <= 1'b1;
      cpu_data <= ~d;
      @(posedge clock);
   endtask : io_write

   // start of a machine cycle, once wait is released or after 40 clocks of waiting
   task mcycle;
      int n;
      n = 0;
      while (wait_n !== 1'b1 && n < 40)
      begin
         @(posedge clock);
         n++;
      end
      @(posedge clock);
      machine_cycle_sync <= 1'b1;
      @(posedge clock);
      machine_cycle_sync <= 1'b0;
   endtask : mcycle

   // outside wait source
   task ext_wait(input logic v);
      @(posedge clock);
      external_wait_n <= v;
   endtask : ext_wait
endmodule : cpu_bus_model

// ==== trainer_ports_tb_top.sv ====
// self-checking bench for the trainer port block
`include "trainer_cfg.svh"

module trainer_ports_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hf;
   logic step_pushbutton = 1'b0;
   logic [7:0] monitor_inputs = 8'h00;
   logic [31:0] readdata;
   logic waitrequest, wait_n, machine_cycle_sync, external_wait_n, io_request_n, write_n;
   logic fd_s, fe_s, ff_s;
   logic [15:0] cpu_address;
   logic [7:0] cpu_data, bus_monitor_leds, first_port_leds, second_port_leds;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] rd_q[$];
   logic [2:0] st_q[$];
   logic [9:0] cfg = 10'h027;
   logic [7:0] e1 = 8'h00;
   logic [7:0] e2 = 8'h00;
   logic [9:0] cfgs[3] = '{10'h027, 10'h079, 10'h052};
   logic [7:0] tbl[4] = '{8'hfd, 8'hfe, 8'hff, 8'h12};

   initial
   begin
      forever #50 clock = ~clock;
   end

   trainer_ports #(.DEBOUNCE_CYCLES(4)) dut
   (
      .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .cpu_address(cpu_address), .cpu_data(cpu_data),
      .io_request_n(io_request_n), .write_n(write_n), .machine_cycle_sync(machine_cycle_sync),
      .external_wait_n(external_wait_n), .wait_n(wait_n), .write_strobe_addr_fd(fd_s),
      .write_strobe_addr_fe(fe_s), .write_strobe_addr_ff(ff_s),
      .step_pushbutton(step_pushbutton), .monitor_inputs(monitor_inputs),
      .bus_monitor_leds(bus_monitor_leds), .first_port_leds(first_port_leds),
      .second_port_leds(second_port_leds)
   );

   cpu_bus_model cpu
   (
      .clock(clock), .wait_n(wait_n), .cpu_address(cpu_address), .cpu_data(cpu_data),
      .io_request_n(io_request_n), .write_n(write_n),
      .machine_cycle_sync(machine_cycle_sync), .external_wait_n(external_wait_n)
   );

   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task automatic report(input logic ok, input logic [31:0] got, exp);
      checks_done++;
      if (!ok)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : report
   task automatic cmp_word(input logic [31:0] got, exp);
      report(got === exp, got, exp);
   endtask : cmp_word
   task automatic cmp_led(input logic [7:0] got, exp);
      report(got === exp, 32'(got), 32'(exp));
   endtask : cmp_led
   task automatic cmp_strobe(input logic [2:0] got, exp);
      report(got === exp, 32'(got), 32'(exp));
   endtask : cmp_strobe
   task automatic cmp_bit(input logic got, exp);
      report(got === exp, 32'(got), 32'(exp));
   endtask : cmp_bit
   task end_of_test;
      if (num_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   // result watcher and timeout
   always @(posedge clock)
   begin
      cycles++;
      if (read && waitrequest === 1'b0)
         cmp_word(readdata, rd_q.pop_front());
      if ({ff_s, fe_s, fd_s} !== 3'b000)
         cmp_strobe({ff_s, fe_s, fd_s}, st_q.size() ? st_q.pop_front() : 3'b000);
      if (cycles == 5000)
      begin
         num_errors++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // drivers
   // ----------------------------------------------------------------
   task av_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      write <= 1'b1;
      address <= a;
      writedata <= d;
      do @(posedge clock); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask : av_wr
   task av_rd(input logic [3:0] a, input logic [31:0] exp);
      rd_q.push_back(exp);
      @(posedge clock);
      read <= 1'b1;
      address <= a;
      do @(posedge clock); while (waitrequest !== 1'b0);
      read <= 1'b0;
   endtask : av_rd
   task set_cfg(input logic [9:0] c);
      cfg = c;
      av_wr(`REG_CTRL, {22'h0, c});
      av_rd(`REG_CTRL, {22'h0, c});
   endtask : set_cfg
   task io(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] p1, px, py;
      p1 = {6'h3f, cfg[1:0]};
      px = {6'h3f, cfg[3:2]};
      py = {6'h3f, cfg[5:4]};
      if (a[7:2] == 6'h3f)
         st_q.push_back({a == 8'hff, a == 8'hfe, a == 8'hfd});
      if (a == p1)
         e1 = d;
      if (cfg[6] && a == px)
         e2[3:0] = d[3:0];
      if (cfg[6] && a == py)
         e2[7:4] = d[7:4];
      if (!cfg[6] && a == px)
         e2 = d;
      cpu.io_write({8'($urandom), a}, d);
      @(posedge clock);
      cmp_led(first_port_leds, e1);
      cmp_led(second_port_leds, e2);
      cmp_led(bus_monitor_leds, ~d);
   endtask : io

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(91));
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      av_rd(`REG_CTRL, 32'h27);
      av_rd(4'h2, 32'h0);
      av_wr(4'h6, 32'h3ff);
      av_wr(`REG_FIRST_PORT, 32'hff);
      av_rd(`REG_CTRL, 32'h27);
      av_rd(`REG_FIRST_PORT, 32'h0);
      av_rd(`REG_STATUS, 32'h0);
      for (int k = 0; k < 3; k++)
      begin
         set_cfg(cfgs[k]);
         repeat (8) io(tbl[$urandom_range(3)], 8'($urandom));
         av_rd(`REG_FIRST_PORT, {24'h0, e1});
         av_rd(`REG_SECOND_PORT, {24'h0, e2});
      end
      set_cfg(10'h0a7);
      repeat (4)
      begin
         monitor_inputs <= 8'($urandom);
         repeat (2) @(posedge clock);
         cmp_led(second_port_leds, monitor_inputs);
      end
      set_cfg(10'h327);
      cmp_led(second_port_leds, e2);
      cmp_bit(wait_n, 1'b0);
      step_pushbutton <= 1'b1;
      repeat (2) @(posedge clock);
      step_pushbutton <= 1'b0;
      repeat (12) @(posedge clock);
      cmp_bit(wait_n, 1'b0);
      repeat (2)
      begin
         step_pushbutton <= 1'b1;
         for (int n = 0; n < 20 && wait_n !== 1'b1; n++) @(posedge clock);
         cmp_bit(wait_n, 1'b1);
         av_rd(`REG_STATUS, {14'h0, 2'b11, monitor_inputs, cpu_data});
         cpu.mcycle();
         repeat (2) @(posedge clock);
         cmp_bit(wait_n, 1'b0);
         repeat (10) @(posedge clock);
         cmp_bit(wait_n, 1'b0);
         step_pushbutton <= 1'b0;
         repeat (12) @(posedge clock);
      end
      set_cfg(10'h127);
      for (int k = 0; k < 4; k++)
      begin
         cpu.ext_wait(k[0]);
         repeat (2) @(posedge clock);
         cmp_bit(wait_n, k[0]);
      end
      cmp_word(32'(rd_q.size() + st_q.size()), 32'h0);
      end_of_test();
   end
endmodule : trainer_ports_tb_top
